// ### rtl/can_irq_pkg.sv
// Constants, register map and carriers for the CAN interrupt flag/mask block.
// Assumes a 32-bit APB master and event pulses from the CAN core.
package can_irq_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] FLAG_OFF = 8'h00;
    localparam logic [7:0] MBMASK_OFF = 8'h04;
    localparam logic [7:0] SRCMASK_OFF = 8'h08;
    localparam logic [7:0] UNREAD_OFF = 8'h0c;
    localparam int MB_COUNT = 16;
    // ----------------------------------------
    // Flag register fields
    // ----------------------------------------
    localparam int F_MBEMPTY = 0;
    localparam int F_UNREAD = 1;
    localparam int F_BUSACT = 4;
    localparam int F_RESET = 8;
    localparam int F_RXMSG = 9;
    localparam int F_REMOTE = 10;
    localparam int F_TXWARN = 11;
    localparam int F_RXWARN = 12;
    localparam int F_ERRPASS = 13;
    localparam int F_BUSOFF = 14;
    localparam int F_OVLD = 15;
    localparam logic [15:0] FLAG_RST = 16'h0100;
    localparam logic [15:0] FLAG_W1C = 16'hfd11;
    // ----------------------------------------
    // Mask registers and line routing
    // ----------------------------------------
    localparam logic [15:0] MBMASK_RST = 16'hffff;
    localparam logic [15:0] SRC_RST = 16'hfeff;
    localparam logic [15:0] SRC_WMASK = 16'hfe13;
    localparam logic [15:0] SRC_ONES = 16'h00ec;
    localparam logic [15:0] OVR_BITS = 16'h9d12;
    localparam logic [15:0] ERR_BITS = 16'h6000;
    localparam logic [15:0] RM_BITS = 16'h0200;
    localparam logic [15:0] SLE_BITS = 16'h0001;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic [15:0] txPendClr;
        logic [15:0] rxPendSet;
        logic [15:0] rxPending;
        logic overload;
        logic busOff;
        logic errPassive;
        logic rxWarn;
        logic txWarn;
        logic remoteReq;
        logic busDominant;
        logic sleepMode;
        logic resetDone;
    } can_evt_s;

    typedef struct packed {
        logic overrun;
        logic errStatus;
        logic rxMessage;
        logic mbEmpty;
    } irq_lines_s;
endpackage : can_irq_pkg

// ### rtl/can_irq_flags.sv
// CAN controller interrupt flags, mailbox mask, source mask and request lines.
// Assumes event inputs are one-cycle pulses synchronous to sys_clk.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Unread flag is read-only, set while any unread-message status bit is set.
// - Mailbox-empty flag sets when a transmit-pending bit clears on completion or abort.
// - Writing 1 clears mailbox-empty flag; writing 0 leaves it.
// - Per-mailbox mask is 16 bits, resets to ones; 0 enables, 1 masks.
// - Mailbox mask bytes swapped: bits 15..8 are mailboxes 7..0, bits 7..0 are 15..8.
// - Transmit mailbox source fires when its transmit-pending bit clears.
// - Receive mailbox source fires when its receive-pending bit sets.
// - Source mask is 16 bits; reset flag is never masked.
// - Source mask bits 15..9 gate overload..receive-message flags; reset to 1.
// - Source mask bits 4, 1, 0 gate bus-activity, unread, mailbox-empty flags.
// - Overload, warnings, remote, reset, bus-activity and unread share the overrun line.
// - Bus-off and error-passive share the error-status line.
// - Receive-message and mailbox-empty flags drive their own lines.
// - Source mask bit 8 reads 0; software writes 0.
// - Source mask bits 7..5, 3, 2 read 1; software writes 1.
// - Reset flag starts at 1, sets when reset finishes; write 1 clears.
// - Unread status sets on overwrite before receive-pending cleared; write 1 clears.
// - Bus-activity flag sets on dominant bit in sleep mode; write 1 clears.
module can_irq_flags #(
    parameter int MAILBOXES = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register bus
    input wire can_irq_pkg::apb_req_s apbReq,
    output can_irq_pkg::apb_rsp_s apbRsp,
    // Events from the CAN core
    input wire can_irq_pkg::can_evt_s evt,
    // Requests to the interrupt controller
    output can_irq_pkg::irq_lines_s irqLines,
    output logic [15:0] mailboxIrq
);
    import can_irq_pkg::*;

    generate
        if (MAILBOXES != MB_COUNT) begin : g_bad_count
            $error("can_irq_flags serves exactly 16 mailboxes");
        end
    endgenerate

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0] flags_r, flags_nxt;
    logic [15:0] mbMask_r, mbMask_nxt;
    logic [15:0] srcMask_r, srcMask_nxt;
    logic [15:0] unreadSt_r, unreadSt_nxt;
    irq_lines_s lines_r, lines_nxt;
    logic [15:0] mbIrq_r, mbIrq_nxt;
    apb_rsp_s rsp_r, rsp_nxt;

    logic [15:0] mbEnable;
    logic [15:0] srcRead;
    logic [15:0] active;
    logic [15:0] unreadSet;
    logic [15:0] flagSet;
    logic setup;
    logic wrAcc;
    logic [15:0] wdata;

    assign setup = apbReq.psel && !apbReq.penable;
    assign wrAcc = apbReq.psel && apbReq.penable && rsp_r.pready && apbReq.pwrite;
    assign wdata = apbReq.pwdata[15:0];
    // Mask bit 8+m steers mailbox m, mask bit m steers mailbox 8+m
    assign mbEnable = ~{mbMask_r[7:0], mbMask_r[15:8]};
    assign srcRead = (srcMask_r & SRC_WMASK) | SRC_ONES;
    // Reset flag sits under a bit that reads 0, so it is never masked
    assign active = flags_r & ~srcRead;

    // ----------------------------------------
    // Per-mailbox events
    // ----------------------------------------
    genvar m;
    generate
        for (m = 0; m < 16; m++) begin : g_mb
            // A new message while the old one still waits overwrites it
            assign unreadSet[m] = evt.rxPendSet[m] && evt.rxPending[m];
            assign unreadSt_nxt[m] = unreadSet[m] ||
                (unreadSt_r[m] && !(wrAcc && apbReq.paddr == UNREAD_OFF && wdata[m ^ 8]));
            assign mbIrq_nxt[m] = mbEnable[m] && (evt.txPendClr[m] || evt.rxPendSet[m]);
        end
    endgenerate

    // ----------------------------------------
    // Flags and masks
    // ----------------------------------------
    always_comb begin
        flagSet = 16'h0000;
        flagSet[F_MBEMPTY] = |evt.txPendClr;
        flagSet[F_BUSACT] = evt.busDominant && evt.sleepMode;
        flagSet[F_RESET] = evt.resetDone;
        flagSet[F_RXMSG] = |(evt.rxPendSet & mbEnable);
        flagSet[F_REMOTE] = evt.remoteReq;
        flagSet[F_TXWARN] = evt.txWarn;
        flagSet[F_RXWARN] = evt.rxWarn;
        flagSet[F_ERRPASS] = evt.errPassive;
        flagSet[F_BUSOFF] = evt.busOff;
        flagSet[F_OVLD] = evt.overload;
        flags_nxt = flags_r;
        // Set wins over a write-1 clear in the same cycle
        if (wrAcc && apbReq.paddr == FLAG_OFF) begin
            flags_nxt = flags_r & ~(wdata & FLAG_W1C);
        end
        if (evt.rxPending == 16'h0000) begin
            flags_nxt[F_RXMSG] = 1'b0;
        end
        flags_nxt = flags_nxt | flagSet;
        flags_nxt[F_UNREAD] = |unreadSt_nxt;
        mbMask_nxt = mbMask_r;
        srcMask_nxt = srcMask_r;
        if (wrAcc && apbReq.paddr == MBMASK_OFF) begin
            mbMask_nxt = wdata;
        end
        if (wrAcc && apbReq.paddr == SRCMASK_OFF) begin
            srcMask_nxt = (wdata & SRC_WMASK) | (srcMask_r & ~SRC_WMASK);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags_r <= FLAG_RST;
            mbMask_r <= MBMASK_RST;
            srcMask_r <= SRC_RST;
            unreadSt_r <= 16'h0000;
        end else begin
            flags_r <= flags_nxt;
            mbMask_r <= mbMask_nxt;
            srcMask_r <= srcMask_nxt;
            unreadSt_r <= unreadSt_nxt;
        end
    end

    // ----------------------------------------
    // Request lines
    // ----------------------------------------
    // Registered so the lines are glitch-free; costs one cycle of latency
    always_comb begin
        lines_nxt.overrun = |(active & OVR_BITS);
        lines_nxt.errStatus = |(active & ERR_BITS);
        lines_nxt.rxMessage = |(active & RM_BITS);
        lines_nxt.mbEmpty = |(active & SLE_BITS);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lines_r <= '0;
            mbIrq_r <= 16'h0000;
        end else begin
            lines_r <= lines_nxt;
            mbIrq_r <= mbIrq_nxt;
        end
    end

    assign irqLines = lines_r;
    assign mailboxIrq = mbIrq_r;

    // ----------------------------------------
    // APB slave: one wait-free access phase
    // ----------------------------------------
    always_comb begin
        rsp_nxt.pready = setup;
        rsp_nxt.pslverr = 1'b0;
        rsp_nxt.prdata = 32'h0000_0000;
        if (setup) begin
            case (apbReq.paddr)
                FLAG_OFF: rsp_nxt.prdata[15:0] = flags_r;
                MBMASK_OFF: rsp_nxt.prdata[15:0] = mbMask_r;
                SRCMASK_OFF: rsp_nxt.prdata[15:0] = srcRead;
                UNREAD_OFF: rsp_nxt.prdata[15:0] = {unreadSt_r[7:0], unreadSt_r[15:8]};
                default: rsp_nxt.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    assign apbRsp = rsp_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence flagW1(int b);
        wrAcc && apbReq.paddr == FLAG_OFF && wdata[b];
    endsequence
    sequence srcRd;
        setup && apbReq.paddr == SRCMASK_OFF;
    endsequence

    chk_unread_track: assert property (flags_r[F_UNREAD] == (|unreadSt_r))
        else $error("unread flag does not follow status");
    chk_empty_set: assert property (|evt.txPendClr |=> flags_r[F_MBEMPTY])
        else $error("mailbox-empty flag not set");
    chk_empty_clear: assert property (flagW1(F_MBEMPTY) ##0 !(|evt.txPendClr) |=> !flags_r[F_MBEMPTY])
        else $error("mailbox-empty flag not cleared");
    chk_empty_keep: assert property (flags_r[F_MBEMPTY] &&
        !(wrAcc && apbReq.paddr == FLAG_OFF && wdata[F_MBEMPTY]) |=> flags_r[F_MBEMPTY])
        else $error("mailbox-empty flag lost");
    chk_swap_rx: assert property (evt.rxPendSet[0] && !mbMask_r[8] |=> mailboxIrq[0])
        else $error("mailbox 0 receive source missing");
    chk_swap_tx: assert property (evt.txPendClr[8] && !mbMask_r[0] |=> mailboxIrq[8])
        else $error("mailbox 8 transmit source missing");
    chk_mask_block: assert property (mbMask_r[8] |=> !mailboxIrq[0])
        else $error("masked mailbox raised source");
    chk_reset_unmasked: assert property (flags_r[F_RESET] |=> irqLines.overrun)
        else $error("reset flag did not request");
    chk_src_read: assert property (srcRd |=> apbRsp.prdata[8] == 1'b0)
        else $error("source mask bit 8 not zero");
    chk_src_ones: assert property (srcRd |=> apbRsp.prdata[7:5] == 3'b111 && apbRsp.prdata[3:2] == 2'b11)
        else $error("source mask fixed ones wrong");
    chk_err_line: assert property ((|(active & ERR_BITS)) |=> irqLines.errStatus)
        else $error("error line not raised");
    chk_idle_low: assert property (active == 16'h0000 |=> irqLines == '0)
        else $error("line high without enabled flag");
    // Status bit and summary flag register on the same edge
    chk_overwrite: assert property (evt.rxPendSet[3] && evt.rxPending[3] |=> unreadSt_r[3] && flags_r[F_UNREAD])
        else $error("overwrite not recorded");
    chk_bus_act: assert property (evt.busDominant && evt.sleepMode |=> flags_r[F_BUSACT])
        else $error("bus activity flag not set");
endmodule : can_irq_flags

`default_nettype wire

// ### tb/irq_ctrl_model.sv
// Stand-in for the processor interrupt controller: latches each request line.
// Assumes registered, active-high request levels on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Request lines in, latched requests out
    input wire can_irq_pkg::irq_lines_s irqLines,
    input wire logic ack,
    output logic [3:0] latched
);
    import can_irq_pkg::*;
    logic [3:0] seen_r;
    logic [3:0] seen_nxt;
    // Sticky, so a request is not lost while the core is busy elsewhere
    always_comb begin
        seen_nxt = ack ? 4'h0 : (seen_r | irqLines);
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seen_r <= 4'h0;
        end else begin
            seen_r <= seen_nxt;
        end
    end
    assign latched = seen_r;
endmodule : irq_ctrl_model
`default_nettype wire

// ### tb/can_interrupt_flag_mask_test.sv
// Self-checking bench for the CAN interrupt flag and mask block.
// Assumes the one-access-cycle APB slave and one-cycle event pulses of the design.
`timescale 1ns/1ps
`default_nettype none
module can_interrupt_flag_mask_test;
    import can_irq_pkg::*;
    typedef struct {int k; logic [15:0] flag; logic [3:0] ln;} row_s;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    can_evt_s evt = '0;
    can_evt_s base = '0;
    irq_lines_s lines;
    logic [15:0] mbIrq;
    logic [15:0] mbGot;
    logic ack = 1'b0;
    logic [3:0] latched;
    logic [31:0] rd;
    logic serr;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    // Source mask fully open; last row checks the sleep-mode qualifier
    row_s rows[9] = '{'{0, 16'h8000, 4'h8}, '{1, 16'h4000, 4'h4}, '{2, 16'h2000, 4'h4},
        '{3, 16'h1000, 4'h8}, '{4, 16'h0800, 4'h8}, '{5, 16'h0400, 4'h8},
        '{6, 16'h0010, 4'h8}, '{7, 16'h0001, 4'h1}, '{8, 16'h0000, 4'h0}};
    // ----------------------------------------
    // Design, partner and clock
    // ----------------------------------------
    can_irq_flags #(.MAILBOXES(16)) can_irq_flags_inst (.sys_clk(sys_clk), .rst(rst), .apbReq(req),
        .apbRsp(rsp), .evt(evt), .irqLines(lines), .mailboxIrq(mbIrq));
    irq_ctrl_model irq_ctrl_model_inst (.sys_clk(sys_clk), .rst(rst), .irqLines(lines), .ack(ack),
        .latched(latched));
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            summarize();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task summarize();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do @(posedge sys_clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        serr = rsp.pslverr;
        req <= '0;
    endtask : apb
    task pulse(input can_evt_s v);
        @(posedge sys_clk);
        evt <= v | base;
        @(posedge sys_clk);
        evt <= base;
        #1 mbGot = mbIrq;
    endtask : pulse
    function automatic can_evt_s evOf(input int k);
        can_evt_s e;
        e = '0;
        case (k)
            0: e.overload = 1'b1;
            1: e.busOff = 1'b1;
            2: e.errPassive = 1'b1;
            3: e.rxWarn = 1'b1;
            4: e.txWarn = 1'b1;
            5: e.remoteReq = 1'b1;
            6: e = '{busDominant: 1'b1, sleepMode: 1'b1, default: '0};
            7: e.txPendClr[5] = 1'b1;
            default: e.busDominant = 1'b1;
        endcase
        return e;
    endfunction : evOf
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        apb(0, FLAG_OFF, 0); chk(rd, 32'h0100);
        chk(lines, 4'h8);
        apb(0, MBMASK_OFF, 0); chk(rd, 32'hffff);
        apb(0, SRCMASK_OFF, 0); chk(rd, 32'hfeff);
        apb(0, UNREAD_OFF, 0); chk(rd, 32'h0000);
        apb(1, FLAG_OFF, 32'h0100); apb(0, FLAG_OFF, 0); chk(rd, 32'h0000);
        pulse('{resetDone: 1'b1, default: '0});
        apb(0, FLAG_OFF, 0); chk(rd, 32'h0100);
        apb(1, FLAG_OFF, 32'h0100);
        apb(1, SRCMASK_OFF, 0); apb(0, SRCMASK_OFF, 0); chk(rd, 32'h00ec);
        foreach (rows[i]) begin
            pulse(evOf(rows[i].k));
            chk(mbGot, 0);
            apb(0, FLAG_OFF, 0); chk(rd, rows[i].flag);
            chk(lines, rows[i].ln);
            apb(1, FLAG_OFF, 32'hffff);
        end
        // Masked source: flag sets but no line rises
        apb(1, SRCMASK_OFF, 32'hffff);
        pulse(evOf(1));
        apb(0, FLAG_OFF, 0); chk(rd, 32'h4000);
        chk(lines, 4'h0);
        apb(1, FLAG_OFF, 32'h4000);
        pulse(evOf(7));
        apb(1, FLAG_OFF, 0); apb(0, FLAG_OFF, 0); chk(rd, 32'h0001);
        apb(1, FLAG_OFF, 1); apb(0, FLAG_OFF, 0); chk(rd, 32'h0000);
        // Mailbox 3 open through the byte-swapped bit 11
        apb(1, SRCMASK_OFF, 0);
        apb(1, MBMASK_OFF, 32'hf7ff);
        base.rxPending[3] = 1'b1;
        pulse('{rxPendSet: 16'h0008, default: '0}); chk(mbGot, 16'h0008);
        pulse('{txPendClr: 16'h0008, default: '0}); chk(mbGot, 16'h0008);
        pulse('{rxPendSet: 16'h0800, default: '0}); chk(mbGot, 16'h0000);
        apb(0, UNREAD_OFF, 0); chk(rd, 32'h0800);
        apb(0, FLAG_OFF, 0); chk(rd, 32'h0203);
        chk(lines, 4'hb);
        apb(1, UNREAD_OFF, 32'h0800); apb(0, FLAG_OFF, 0); chk(rd, 32'h0201);
        // Mailboxes 0 and 8 open through bits 8 and 0
        apb(1, MBMASK_OFF, 32'hfefe);
        pulse('{rxPendSet: 16'h0001, default: '0}); chk(mbGot, 16'h0001);
        pulse('{txPendClr: 16'h0100, default: '0}); chk(mbGot, 16'h0100);
        apb(0, 8'h10, 0); chk({rd[30:0], serr}, 32'h1);
        chk(latched, 4'hf);
        // Acknowledge empties the partner, which then re-latches the live lines
        @(posedge sys_clk);
        ack <= 1'b1;
        @(posedge sys_clk);
        ack <= 1'b0;
        @(posedge sys_clk);
        #1 chk(latched, 4'h3);
        // Reset in mid-run restores every register
        @(posedge sys_clk);
        rst <= 1'b1;
        base = '0;
        evt <= '0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        apb(0, FLAG_OFF, 0); chk(rd, 32'h0100);
        chk(lines, 4'h8);
        apb(0, MBMASK_OFF, 0); chk(rd, 32'hffff);
        apb(0, SRCMASK_OFF, 0); chk(rd, 32'hfeff);
        apb(0, UNREAD_OFF, 0); chk(rd, 32'h0000);
        summarize();
    end
endmodule : can_interrupt_flag_mask_test
`default_nettype wire
